// file: hdl/sac_pkg.sv
// Package of constants and types for the converter control block
package sac_pkg;
  localparam logic [3:0] SAC_ADDR_CTL1 = 4'h0;
  localparam logic [3:0] SAC_ADDR_CTL2 = 4'h4;
  localparam logic [3:0] SAC_ADDR_RESH = 4'h8;
  localparam logic [3:0] SAC_ADDR_RESL = 4'hc;
  localparam logic [7:0] SAC_CTL1_RST = 8'h00;
  localparam logic [7:0] SAC_CTL2_RST = 8'h00;
  localparam int SAC_BIT_DONE = 3;
  localparam int SAC_BIT_BUSY = 2;
  localparam int SAC_BIT_START = 0;
  localparam int SAC_BIT_PREC = 7;
  localparam int SAC_BIT_TRIG = 4;
  localparam int SAC_BIT_IEN = 3;
  localparam int SAC_BIT_CONT = 2;
  localparam logic [3:0] SAC_MAX_CHANNEL = 4'hb;
  localparam logic [4:0] SAC_SAMPLE_00 = 5'h04;
  localparam logic [4:0] SAC_SAMPLE_01 = 5'h07;
  localparam logic [4:0] SAC_SAMPLE_10 = 5'h0a;
  localparam logic [4:0] SAC_SAMPLE_11 = 5'h10;
  localparam logic [3:0] SAC_BITS_10 = 4'h9;
  localparam logic [3:0] SAC_BITS_8 = 4'h7;
  localparam logic [2:0] SAC_DIV_RST = 3'h0;
  typedef enum logic [1:0] {SAC_IDLE, SAC_SAMPLE, SAC_COMPARE, SAC_XFER} sac_state_t;
endpackage

// file: hdl/sac_core_if.sv
// Interface between register block and conversion engine
`timescale 1ns/1ps
interface sac_core_if;
  logic start;
  logic halt;
  logic [3:0] channel;
  logic prec8;
  logic [1:0] sample_sel;
  logic [1:0] div_sel;
  logic busy;
  logic done;
  logic [9:0] result;
  modport ctl (output start, halt, channel, prec8, sample_sel, div_sel,
    input busy, done, result);
  modport eng (input start, halt, channel, prec8, sample_sel, div_sel,
    output busy, done, result);
endinterface

// file: hdl/sac_clkdiv.sv
// Converter clock tick generator from the machine clock
`timescale 1ns/1ps
module sac_clkdiv
  import sac_pkg::*;
(
  input wire logic clk, // Machine clock
  input wire logic rst, // Sync reset
  input wire logic [1:0] div_sel, // Divider select
  output logic tick // One-cycle converter clock tick
);
  typedef struct packed {
    logic [2:0] cnt;
  } sac_div_state_t;
  sac_div_state_t s_q, s_d;
  logic [2:0] mask;
  always_comb begin
    s_d = s_q;
    mask = 3'((4'h1 << div_sel) - 4'h1);
    s_d.cnt = 3'(s_q.cnt + 3'h1) & mask;
    tick = ((s_q.cnt & mask) == mask);
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.cnt <= SAC_DIV_RST;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// file: hdl/sac_engine.sv
// Sample and successive approximation sequencer
`timescale 1ns/1ps
module sac_engine
  import sac_pkg::*;
(
  input wire logic clk, // Machine clock
  input wire logic rst, // Sync reset
  input wire logic tick, // Converter clock tick
  input wire logic comp_in, // Comparator: input at or above trial
  output logic [3:0] mux_sel, // Analog mux select
  output logic sample_en, // Sample-and-hold tracking
  output logic [9:0] trial, // Trial code to the DAC
  sac_core_if.eng bus // Control side
);
  typedef struct packed {
    sac_state_t st;
    logic [4:0] cnt;
    logic [3:0] bitn;
    logic [9:0] sar;
    logic [9:0] res;
    logic [3:0] chan;
    logic done;
  } sac_eng_state_t;
  sac_eng_state_t s_q, s_d;
  logic [4:0] slen;
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (bus.sample_sel)
      2'b00: slen = SAC_SAMPLE_00;
      2'b01: slen = SAC_SAMPLE_01;
      2'b10: slen = SAC_SAMPLE_10;
      default: slen = SAC_SAMPLE_11;
    endcase
    case (s_q.st)
      SAC_SAMPLE: begin
        if (tick) begin
          if (s_q.cnt == 5'(slen - 5'h1)) begin
            s_d.st = SAC_COMPARE;
            s_d.bitn = SAC_BITS_10;
            s_d.sar = 10'h000;
          end else begin
            s_d.cnt = 5'(s_q.cnt + 5'h1);
          end
        end
      end
      SAC_COMPARE: begin
        // one decision per tick, MSB first
        if (tick) begin
          s_d.sar[s_q.bitn] = comp_in;
          // Eight-bit mode stops after the top eight bits
          if (s_q.bitn == (bus.prec8 ? 4'(SAC_BITS_10 - SAC_BITS_8) : 4'h0)) begin
            s_d.st = SAC_XFER;
          end else begin
            s_d.bitn = 4'(s_q.bitn - 4'h1);
          end
        end
      end
      SAC_XFER: begin
        s_d.res = s_q.sar;
        s_d.done = 1'b1;
        s_d.st = SAC_IDLE;
      end
      default: begin
        s_d.st = SAC_IDLE;
      end
    endcase
    if (bus.start) begin
      s_d.st = SAC_SAMPLE;
      s_d.cnt = 5'h00;
      s_d.chan = bus.channel;
    end
    if (bus.halt) begin
      s_d.st = SAC_IDLE;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign mux_sel = s_q.chan;
  assign sample_en = (s_q.st == SAC_SAMPLE);
  assign trial = s_q.sar | (10'h001 << s_q.bitn);
  assign bus.busy = (s_q.st != SAC_IDLE);
  assign bus.done = s_q.done;
  assign bus.result = s_q.res;
endmodule

// file: hdl/sac_top.sv
// Converter control registers with Avalon-MM slave
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module sac_top
  import sac_pkg::*;
(
  input wire logic CLK, // Machine clock, 100 MHz
  input wire logic RST, // Sync reset, active high
  input wire logic [3:0] AVS_ADDRESS, // Byte address
  input wire logic AVS_READ, // Read request
  input wire logic AVS_WRITE, // Write request
  input wire logic [3:0] AVS_BYTEENABLE, // Byte enables
  input wire logic [31:0] AVS_WRITEDATA, // Write data
  input wire logic AVS_RMW, // Read is part of read-modify-write
  output logic [31:0] AVS_READDATA, // Read data
  output logic AVS_WAITREQUEST, // Wait request
  input wire logic LOW_POWER_STOP, // Stop or watch mode entry
  input wire logic COMPOSITE_TIMER_OUTPUT, // External trigger
  input wire logic COMP_IN, // Comparator result
  output logic [3:0] ANALOG_CHANNEL_SELECT, // Mux select
  output logic SAMPLE_EN, // Sample-and-hold tracking
  output logic [9:0] TRIAL_CODE, // Trial code to DAC
  output logic IRQ // Interrupt request
);
  typedef struct packed {
    logic [3:0] chan;
    logic done;
    logic [7:0] ctl2;
    logic trig;
    logic ack;
    logic [31:0] rdata;
  } sac_top_state_t;
  sac_top_state_t s_q, s_d;
  sac_core_if cif();
  logic tick;
  logic wr_hit;
  logic [7:0] wd;
  logic [7:0] rbyte;
  logic [9:0] res_v;
  logic trig_rise;

  sac_clkdiv u_div (
    .clk(CLK),
    .rst(RST),
    .div_sel(s_q.ctl2[1:0]),
    .tick(tick)
  );
  sac_engine u_eng (
    .clk(CLK),
    .rst(RST),
    .tick(tick),
    .comp_in(COMP_IN),
    .mux_sel(ANALOG_CHANNEL_SELECT),
    .sample_en(SAMPLE_EN),
    .trial(TRIAL_CODE),
    .bus(cif.eng)
  );

  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    wd = AVS_WRITEDATA[7:0];
    // Write lands at the edge where waitrequest is low
    wr_hit = AVS_WRITE && s_q.ack && AVS_BYTEENABLE[0];
    cif.start = 1'b0;
    res_v = s_q.ctl2[SAC_BIT_PREC] ? {2'b00, cif.result[9:2]} : cif.result;
    s_d.trig = s_q.ctl2[SAC_BIT_TRIG] & COMPOSITE_TIMER_OUTPUT;
    trig_rise = s_d.trig & ~s_q.trig;
    if (s_q.ctl2[SAC_BIT_CONT] && trig_rise) begin
      cif.start = 1'b1;
    end
    if ((AVS_READ || AVS_WRITE) && !s_q.ack) begin
      s_d.ack = 1'b1;
    end
    if (wr_hit && AVS_ADDRESS == SAC_ADDR_CTL1) begin
      s_d.chan = wd[7:4];
      if (!wd[SAC_BIT_DONE]) begin
        s_d.done = 1'b0;
      end
      // start on one; ignored in continuous
      if (wd[SAC_BIT_START] && !s_q.ctl2[SAC_BIT_CONT]) begin
        cif.start = 1'b1;
      end
    end
    if (wr_hit && AVS_ADDRESS == SAC_ADDR_CTL2) begin
      s_d.ctl2 = wd;
    end
    // set wins over clear; also over restart
    if (cif.done) begin
      s_d.done = 1'b1;
    end
    // Latest channel passes straight through on a start write
    cif.channel = s_d.chan;
    cif.halt = LOW_POWER_STOP;
    cif.prec8 = s_q.ctl2[SAC_BIT_PREC];
    cif.sample_sel = s_q.ctl2[6:5];
    cif.div_sel = s_q.ctl2[1:0];
    case (AVS_ADDRESS)
      // RMW read done as one; start reads zero
      SAC_ADDR_CTL1: rbyte = {s_q.chan, s_q.done | AVS_RMW, cif.busy, 2'b00};
      SAC_ADDR_CTL2: rbyte = s_q.ctl2;
      SAC_ADDR_RESH: rbyte = {6'h00, res_v[9:8]};
      SAC_ADDR_RESL: rbyte = res_v[7:0];
      default: rbyte = 8'h00;
    endcase
    if (AVS_READ && !s_q.ack) begin
      s_d.rdata = {24'h000000, rbyte};
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      s_q.chan <= 4'h0;
      s_q.done <= 1'b0;
      s_q.ctl2 <= SAC_CTL2_RST;
      s_q.trig <= 1'b0;
      s_q.ack <= 1'b0;
      s_q.rdata <= 32'h00000000;
    end else begin
      s_q <= s_d;
    end
  end

  assign IRQ = s_q.done & s_q.ctl2[SAC_BIT_IEN];
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !s_q.ack;
  assign AVS_READDATA = s_q.rdata;
endmodule

// file: tb/sac_properties.sv
// Port assertions for the converter control block
`timescale 1ns/1ps
module sac_properties (
  input wire logic CLK, // Clock
  input wire logic RST, // Reset
  input wire logic [3:0] AVS_ADDRESS, // Address
  input wire logic AVS_READ, // Read
  input wire logic AVS_WRITE, // Write
  input wire logic AVS_RMW, // RMW read
  input wire logic [31:0] AVS_READDATA, // Read data
  input wire logic AVS_WAITREQUEST, // Wait
  input wire logic LOW_POWER_STOP, // Stop mode
  input wire logic [3:0] ANALOG_CHANNEL_SELECT, // Mux
  input wire logic SAMPLE_EN, // Tracking
  input wire logic IRQ // Interrupt
);
  logic rd0;
  assign rd0 = AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 4'h0;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_stop2;
    LOW_POWER_STOP ##1 LOW_POWER_STOP;
  endsequence
  sequence s_track4;
    SAMPLE_EN [*4];
  endsequence
  chan_range_a: assert property (ANALOG_CHANNEL_SELECT <= 4'hb)
    else $error("channel out of range");
  chan_hold_a: assert property (SAMPLE_EN && $past(SAMPLE_EN) |-> $stable(ANALOG_CHANNEL_SELECT))
    else $error("channel moved while sampling");
  start_zero_a: assert property (rd0 |-> !AVS_READDATA[0])
    else $error("start bit read as one");
  rmw_done_a: assert property (rd0 && AVS_RMW |-> AVS_READDATA[3])
    else $error("rmw read of done not one");
  busy_read_a: assert property (rd0 && SAMPLE_EN && $past(SAMPLE_EN) |-> AVS_READDATA[2])
    else $error("busy low while sampling");
  stop_halt_a: assert property (s_stop2 |-> !SAMPLE_EN)
    else $error("sampling during stop");
  sample_min_a: assert property ($rose(SAMPLE_EN) && !LOW_POWER_STOP |-> s_track4)
    else $error("sampling too short");
  irq_clear_a: assert property ($fell(IRQ) |-> $past(AVS_WRITE && !AVS_WAITREQUEST) || $past(RST))
    else $error("interrupt fell without write");
endmodule
bind sac_top sac_properties sac_properties_i (.CLK, .RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
  .AVS_RMW, .AVS_READDATA, .AVS_WAITREQUEST, .LOW_POWER_STOP, .ANALOG_CHANNEL_SELECT,
  .SAMPLE_EN, .IRQ);

// file: tb/sac_comparator.sv
// Sample-and-hold and comparator model
`timescale 1ns/1ps
module sac_comparator (
  input wire logic clk, // Clock
  input wire logic [3:0] sel, // Channel
  input wire logic track, // Tracking
  input wire logic [9:0] trial, // Trial code
  output logic comp // Held level at or above trial
);
  logic [9:0] held = 10'h000;
  function automatic logic [9:0] lvl(input logic [3:0] c);
    return 10'h2d5 ^ {c, c, 2'h1};
  endfunction
  always @(posedge clk) if (track) held <= lvl(sel);
  assign comp = held >= trial;
endmodule

// file: tb/sac_top_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module sac_top_tb;
  import sac_pkg::*;
  logic CLK = 0, RST = 1, AVS_READ = 0, AVS_WRITE = 0, AVS_RMW = 0, LOW_POWER_STOP = 0;
  logic COMPOSITE_TIMER_OUTPUT = 0, AVS_WAITREQUEST, COMP_IN, SAMPLE_EN, IRQ;
  logic [3:0] AVS_ADDRESS = 4'h0, ANALOG_CHANNEL_SELECT;
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, q;
  logic [9:0] TRIAL_CODE, v;
  int n_mismatch = 0, num_checks = 0, ns = 0;
  always #5 CLK = ~CLK;
  always @(negedge CLK) ns += SAMPLE_EN;
  sac_top sac_top_i (.CLK, .RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_BYTEENABLE(4'hf),
    .AVS_WRITEDATA, .AVS_RMW, .AVS_READDATA, .AVS_WAITREQUEST, .LOW_POWER_STOP,
    .COMPOSITE_TIMER_OUTPUT, .COMP_IN, .ANALOG_CHANNEL_SELECT, .SAMPLE_EN, .TRIAL_CODE, .IRQ);
  sac_comparator sac_comparator_i (.clk(CLK), .sel(ANALOG_CHANNEL_SELECT), .track(SAMPLE_EN),
    .trial(TRIAL_CODE), .comp(COMP_IN));
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic b(input logic w, input logic [3:0] a, input logic [7:0] d, input logic r);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {24'h0, d};
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_RMW <= r;
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_WRITE <= 0;
    AVS_READ <= 0;
    AVS_RMW <= 0;
    @(posedge CLK);
  endtask
  task automatic wirq;
    for (int i = 0; i < 400 && IRQ !== 1'b1; i++) @(posedge CLK);
    ck(IRQ, 1);
  endtask
  task automatic t_soft;
    logic [7:0] c2 [4] = '{8'h08, 8'h29, 8'hca, 8'h6b};
    int sn [4] = '{4, 7, 10, 16};
    logic [3:0] ch;
    int e;
    for (int k = 0; k < 4; k++) begin
      ch = 4'(3 * k + 2);
      v = sac_comparator_i.lvl(ch);
      e = sn[k] << k;
      b(1, SAC_ADDR_CTL2, c2[k], 0);
      b(0, SAC_ADDR_CTL2, 8'h00, 0);
      ck(q, {24'h0, c2[k]});
      ns = 0;
      b(1, SAC_ADDR_CTL1, {ch, 4'h1}, 0);
      ck(ANALOG_CHANNEL_SELECT, ch);
      wirq;
      ck(ns > e - (1 << k) && ns <= e + (1 << k), 1);
      b(0, SAC_ADDR_CTL1, 8'h00, 0);
      ck(q, {24'h0, ch, 4'h8});
      b(0, SAC_ADDR_RESH, 8'h00, 0);
      ck(q, k == 2 ? 32'h0 : 32'(v[9:8]));
      b(0, SAC_ADDR_RESL, 8'h00, 0);
      ck(q, k == 2 ? 32'(v[9:2]) : 32'(v[7:0]));
      b(1, SAC_ADDR_CTL1, {ch, 4'h8}, 0);
      ck(IRQ, 1);
      b(1, SAC_ADDR_CTL1, {ch, 4'h0}, 0);
      ck(IRQ, 0);
      b(0, SAC_ADDR_CTL1, 8'h00, 1);
      ck(q, {24'h0, ch, 4'h8});
    end
    $display("t_soft done");
  endtask
  task automatic t_restart;
    v = sac_comparator_i.lvl(4'h7);
    b(1, SAC_ADDR_CTL1, 8'h71, 0);
    repeat (90) @(posedge CLK);
    b(0, SAC_ADDR_CTL1, 8'h00, 0);
    ck(q[2], 1);
    repeat (60) @(posedge CLK);
    b(1, SAC_ADDR_CTL1, 8'h70, 0);
    b(0, SAC_ADDR_CTL1, 8'h00, 0);
    ck(q[2], 1);
    b(1, SAC_ADDR_CTL1, 8'h71, 0);
    ck(SAMPLE_EN, 1);
    wirq;
    b(1, SAC_ADDR_CTL1, 8'h70, 0);
    b(0, SAC_ADDR_RESL, 8'h00, 0);
    ck(q, 32'(v[7:0]));
    $display("t_restart done");
  endtask
  task automatic t_cont;
    v = sac_comparator_i.lvl(4'h3);
    b(1, SAC_ADDR_CTL2, 8'h1c, 0);
    b(1, SAC_ADDR_CTL1, 8'h31, 0);
    repeat (8) @(posedge CLK);
    ck(SAMPLE_EN, 0);
    COMPOSITE_TIMER_OUTPUT <= 1;
    wirq;
    b(0, SAC_ADDR_RESL, 8'h00, 0);
    ck(q, 32'(v[7:0]));
    b(1, SAC_ADDR_CTL2, 8'h14, 0);
    ck(IRQ, 0);
    COMPOSITE_TIMER_OUTPUT <= 0;
    b(1, SAC_ADDR_CTL1, 8'h30, 0);
    b(1, SAC_ADDR_CTL2, 8'h0c, 0);
    COMPOSITE_TIMER_OUTPUT <= 1;
    repeat (8) @(posedge CLK);
    ck(SAMPLE_EN, 0);
    COMPOSITE_TIMER_OUTPUT <= 0;
    $display("t_cont done");
  endtask
  task automatic t_stop;
    b(1, SAC_ADDR_CTL2, 8'h6b, 0);
    b(1, SAC_ADDR_CTL1, 8'h01, 0);
    repeat (20) @(posedge CLK);
    LOW_POWER_STOP <= 1;
    repeat (3) @(posedge CLK);
    LOW_POWER_STOP <= 0;
    b(0, SAC_ADDR_CTL1, 8'h00, 0);
    ck(q[2], 0);
    repeat (250) @(posedge CLK);
    ck(IRQ, 0);
    $display("t_stop done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge CLK);
    RST <= 0;
    @(posedge CLK);
    b(0, SAC_ADDR_CTL1, 8'h00, 0);
    ck(q, 32'h0);
    t_soft;
    t_restart;
    t_cont;
    t_stop;
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    n_mismatch++;
    stop_test;
  end
endmodule
